// File: hdl/hpi_top.sv
/*
 hpi_top: dual 24-bit input register with two-wire handshake toward an
 external peripheral and a dataway-style command port (n, a, f, strobe).
 assumes peripheral inputs are synchronous to clock; dataway cycle end is
 given by the fall of cmd_strobe.
*/
// Summary of operation
// R1: two independent 24-bit input registers; peripheral is master or slave.
// R2: word is latched on a strobe from the peripheral, not internal timing.
// R3: peripheral-master: peripheral presents word and raises master_sync.
// R4: peripheral-master: slave_sync raised after the dataway cycle taking word.
// R5: peripheral-slave: request code makes device raise master_sync.
// R6: peripheral-slave: peripheral places word and strobes with slave_sync.
// R7: repeat mode works without LAM; Q says whether transfer occurs.
// R8: pattern mode: trigger pulse latches word and raises L.
// R9: static mode: register follows inputs except during read; no L.
// R10: handshake modes raise L on latch, clear L on read.
// R11: repeat mode read answers Q=1 only for a fresh word.
`timescale 1ns/10ps
`default_nettype none
module hpi_top
   import hpi_pkg::*;
#(
   parameter int unsigned WIDTH = HPI_WORD_WIDTH
) (
   input wire logic clock,
   input wire logic sys_rst,
   // per-channel mode straps
   input wire hpi_mode_type mode_ch0,
   input wire hpi_mode_type mode_ch1,
   // peripheral side, channel 0
   input wire logic [WIDTH-1:0] periph_data_ch0,
   input wire logic master_sync_in_ch0,
   output logic master_sync_out_ch0,
   input wire logic slave_sync_in_ch0,
   output logic slave_sync_out_ch0,
   input wire logic trigger_ch0,
   // peripheral side, channel 1
   input wire logic [WIDTH-1:0] periph_data_ch1,
   input wire logic master_sync_in_ch1,
   output logic master_sync_out_ch1,
   input wire logic slave_sync_in_ch1,
   output logic slave_sync_out_ch1,
   input wire logic trigger_ch1,
   // dataway side
   input wire logic cmd_strobe,
   input wire logic cmd_station,
   input wire logic cmd_sub,
   input wire logic [4:0] cmd_func,
   output logic [WIDTH-1:0] read_data,
   output logic q_resp,
   output logic lam
);
   localparam int unsigned NCH = HPI_CHANNELS;

   logic [WIDTH-1:0] data_in [NCH];
   logic ms_in [NCH];
   logic ss_in [NCH];
   logic trig [NCH];
   hpi_mode_type mode [NCH];
   logic ms_out [NCH];
   logic ss_out [NCH];
   logic [WIDTH-1:0] word_q [NCH];
   logic lam_q [NCH];
   logic lam_en_q [NCH];
   logic take_q [NCH];
   logic strobe_q;
   logic [NCH-1:0] lam_vec;
   logic [WIDTH-1:0] rd_q;
   logic q_q;

   assign data_in[0] = periph_data_ch0;
   assign data_in[1] = periph_data_ch1;
   assign ms_in[0] = master_sync_in_ch0;
   assign ms_in[1] = master_sync_in_ch1;
   assign ss_in[0] = slave_sync_in_ch0;
   assign ss_in[1] = slave_sync_in_ch1;
   assign trig[0] = trigger_ch0;
   assign trig[1] = trigger_ch1;
   assign mode[0] = mode_ch0;
   assign mode[1] = mode_ch1;
   assign master_sync_out_ch0 = ms_out[0];
   assign master_sync_out_ch1 = ms_out[1];
   assign slave_sync_out_ch0 = ss_out[0];
   assign slave_sync_out_ch1 = ss_out[1];

   // dataway cycle end detection
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         strobe_q <= 1'b0;
      end else begin
         strobe_q <= cmd_strobe;
      end
   end

   wire cyc_start = cmd_strobe & ~strobe_q & cmd_station;
   wire cyc_end = ~cmd_strobe & strobe_q;

   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_ch
         logic addr_hit;
         logic rd_cmd;
         logic req_cmd;
         logic latch_evt;
         logic ms_prev_q;
         logic ss_prev_q;
         logic trig_prev_q;
         logic reading_q;
         logic ms_start;
         logic ss_start;

         assign addr_hit = cyc_start & (cmd_sub == 1'(g));
         assign rd_cmd = addr_hit & (cmd_func == HPI_F_READ);
         assign req_cmd = addr_hit & (cmd_func == HPI_F_REQUEST);

         // edge history of peripheral strobes
         always_ff @(posedge clock or posedge sys_rst) begin
            if (sys_rst) begin
               ms_prev_q <= 1'b0;
               ss_prev_q <= 1'b0;
               trig_prev_q <= 1'b0;
            end else begin
               ms_prev_q <= ms_in[g];
               ss_prev_q <= ss_in[g];
               trig_prev_q <= trig[g];
            end
         end

         // the peripheral's own strobe decides the latch moment; a pending
         // L blocks further latches, so a word is kept until a read or clear code drops L
         always_comb begin
            latch_evt = 1'b0;
            unique case (mode[g])
               HPI_MODE_PERIPH_MASTER: latch_evt = ms_in[g] & ~ms_prev_q; // R2 R3
               HPI_MODE_PERIPH_SLAVE: latch_evt = ss_in[g] & ~ss_prev_q; // R6
               HPI_MODE_PATTERN: latch_evt = trig[g] & ~trig_prev_q; // R8
               HPI_MODE_STATIC: latch_evt = 1'b0;
            endcase
            latch_evt = latch_evt & ~lam_q[g];
         end

         // read in progress flag, spans the dataway strobe
         always_ff @(posedge clock or posedge sys_rst) begin
            if (sys_rst) begin
               reading_q <= 1'b0;
            end else if (rd_cmd) begin
               reading_q <= 1'b1;
            end else if (cyc_end) begin
               reading_q <= 1'b0;
            end
         end

         // data register
         always_ff @(posedge clock or posedge sys_rst) begin
            if (sys_rst) begin
               word_q[g] <= '0;
            end else if (mode[g] == HPI_MODE_STATIC) begin
               if (!reading_q && !rd_cmd) begin
                  word_q[g] <= data_in[g]; // R9
               end
            end else if (latch_evt) begin
               word_q[g] <= data_in[g]; // R1 R2
            end
         end

         // L flag: set wins over clear
         always_ff @(posedge clock or posedge sys_rst) begin
            if (sys_rst) begin
               lam_q[g] <= 1'b0;
            end else if (mode[g] == HPI_MODE_STATIC) begin
               lam_q[g] <= 1'b0; // R9
            end else if (latch_evt) begin
               lam_q[g] <= 1'b1; // R10 R8
            end else if (rd_cmd || (addr_hit && cmd_func == HPI_F_CLEAR_LAM)) begin
               lam_q[g] <= 1'b0; // R10
            end
         end

         // L enable mask
         always_ff @(posedge clock or posedge sys_rst) begin
            if (sys_rst) begin
               lam_en_q[g] <= HPI_LAM_ENABLE_RESET[0];
            end else if (addr_hit && cmd_func == HPI_F_ENABLE_LAM) begin
               lam_en_q[g] <= 1'b1;
            end else if (addr_hit && cmd_func == HPI_F_DISABLE_LAM) begin
               lam_en_q[g] <= 1'b0;
            end
         end

         // a successful read in master or pattern mode arms the acknowledge at cycle end
         always_ff @(posedge clock or posedge sys_rst) begin
            if (sys_rst) begin
               take_q[g] <= 1'b0;
            end else if (rd_cmd && lam_q[g]
                         && mode[g] != HPI_MODE_PERIPH_SLAVE) begin
               take_q[g] <= 1'b1;
            end else if (cyc_end) begin
               take_q[g] <= 1'b0;
            end
         end

         assign ss_start = take_q[g] & cyc_end; // R4
         assign ms_start = req_cmd & (mode[g] == HPI_MODE_PERIPH_SLAVE); // R5

         hpi_pulse #(
            .LENGTH(HPI_SYNC_PULSE_CYC)
         ) u_ss (
            .clock(clock),
            .sys_rst(sys_rst),
            .start(ss_start),
            .pulse(ss_out[g])
         );

         hpi_pulse #(
            .LENGTH(HPI_SYNC_PULSE_CYC)
         ) u_ms (
            .clock(clock),
            .sys_rst(sys_rst),
            .start(ms_start),
            .pulse(ms_out[g])
         );

         assign lam_vec[g] = lam_q[g] & lam_en_q[g];
      end
   endgenerate

   // dataway answers captured at command start, held until next command
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         rd_q <= '0;
         q_q <= 1'b0;
      end else if (cyc_start) begin
         rd_q <= '0;
         q_q <= 1'b0;
         unique case (cmd_func)
            HPI_F_READ: begin
               rd_q <= word_q[cmd_sub];
               // static data is always valid
               q_q <= lam_q[cmd_sub] | (mode[cmd_sub] == HPI_MODE_STATIC); // R7 R11
            end
            HPI_F_TEST_LAM: q_q <= lam_q[cmd_sub];
            HPI_F_REQUEST: q_q <= (mode[cmd_sub] == HPI_MODE_PERIPH_SLAVE); // R7
            HPI_F_CLEAR_LAM, HPI_F_ENABLE_LAM, HPI_F_DISABLE_LAM: q_q <= 1'b1;
            default: q_q <= 1'b0;
         endcase
      end
   end

   assign read_data = rd_q;
   assign q_resp = q_q;
   assign lam = |lam_vec;
endmodule
`default_nettype wire

// File: hdl/hpi_pkg.sv
/*
 package for the handshake parallel input register: widths, dataway
 function codes, mode encodings and handshake timing counts.
 assumes a single 100 MHz clock domain.
*/
package hpi_pkg;
   localparam int unsigned HPI_WORD_WIDTH = 24;
   localparam int unsigned HPI_CHANNELS = 2;
   localparam int unsigned HPI_CLOCK_MHZ = 100;
   // dataway function codes used by the block
   localparam logic [4:0] HPI_F_READ = 5'h00;
   localparam logic [4:0] HPI_F_TEST_LAM = 5'h08;
   localparam logic [4:0] HPI_F_CLEAR_LAM = 5'h0a;
   localparam logic [4:0] HPI_F_DISABLE_LAM = 5'h18;
   localparam logic [4:0] HPI_F_REQUEST = 5'h19;
   localparam logic [4:0] HPI_F_ENABLE_LAM = 5'h1a;
   // operating modes, set per channel by static inputs
   typedef enum logic [1:0] {
      HPI_MODE_PERIPH_MASTER = 2'h0,
      HPI_MODE_PERIPH_SLAVE = 2'h1,
      HPI_MODE_PATTERN = 2'h2,
      HPI_MODE_STATIC = 2'h3
   } hpi_mode_type;
   // handshake pulse widths
   localparam int unsigned HPI_SYNC_PULSE_NS = 100;
   localparam int unsigned HPI_SYNC_PULSE_CYC =
      (HPI_SYNC_PULSE_NS * HPI_CLOCK_MHZ + 999) / 1000;
   localparam logic [7:0] HPI_LAM_ENABLE_RESET = 8'h01;
endpackage

// File: hdl/hpi_pulse.sv
/*
 hpi_pulse: stretches a one-cycle start into a pulse of fixed length.
 assumes the single system clock and an active-high asynchronous reset.
*/
`timescale 1ns/10ps
`default_nettype none
module hpi_pulse
   import hpi_pkg::*;
#(
   parameter int unsigned LENGTH = HPI_SYNC_PULSE_CYC
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic start,
   output logic pulse
);
   logic [7:0] count_q;

   // restart on every start; counts down to zero
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         count_q <= 8'h00;
      end else if (start) begin
         count_q <= LENGTH[7:0];
      end else if (count_q != 8'h00) begin
         count_q <= count_q - 8'h01;
      end
   end

   assign pulse = (count_q != 8'h00);
endmodule
`default_nettype wire

// File: sim/hpi_chk.sv
/* hpi_chk: port checker bound into hpi_top.
 assumes one clock domain; ports joined by name. */
`timescale 1ns/10ps
`default_nettype none
module hpi_chk
   import hpi_pkg::*;
#(parameter int unsigned WIDTH = HPI_WORD_WIDTH) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic cmd_strobe,
   input wire logic cmd_station,
   input wire logic cmd_sub,
   input wire logic q_resp,
   input wire logic lam,
   input wire logic master_sync_out_ch1,
   input wire logic slave_sync_out_ch0,
   input wire logic [4:0] cmd_func,
   input wire logic [WIDTH-1:0] read_data,
   input wire hpi_mode_type mode_ch0,
   input wire hpi_mode_type mode_ch1
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);
   // cycle start: strobe rise while addressed
   sequence s_go;
      cmd_strobe && !$past(cmd_strobe) && cmd_station;
   endsequence
   // 10-cycle pulses, seen over their first 8 cycles
   a_req_pulse: assert property ($rose(master_sync_out_ch1)
      |-> master_sync_out_ch1[*8]) else $error("req short");
   a_req_cause: assert property (s_go ##0 (cmd_func == HPI_F_REQUEST && cmd_sub
      && mode_ch1 == HPI_MODE_PERIPH_SLAVE) |-> ##[1:2] master_sync_out_ch1)
      else $error("no req");
   a_ack_pulse: assert property ($rose(slave_sync_out_ch0)
      |-> slave_sync_out_ch0[*8]) else $error("ack short");
   a_ack_late: assert property ($rose(slave_sync_out_ch0)
      |-> !$past(cmd_strobe)) else $error("ack in cycle");
   a_static_lam: assert property (mode_ch0 == HPI_MODE_STATIC
      && mode_ch1 == HPI_MODE_STATIC |-> !lam) else $error("static lam");
   a_static_q: assert property (s_go ##0 (cmd_func == HPI_F_READ && !cmd_sub
      && mode_ch0 == HPI_MODE_STATIC) |=> q_resp) else $error("static q");
   a_unknown_q: assert property (s_go ##0 cmd_func inside {[5'h01:5'h07]}
      |=> !q_resp) else $error("unknown q");
   a_answer_hold: assert property ($changed(read_data) || $changed(q_resp)
      |-> $past(cmd_strobe) && !$past(cmd_strobe, 2) && $past(cmd_station))
      else $error("answer moved");
   c_req: cover property ($rose(master_sync_out_ch1));
   c_ack: cover property ($rose(slave_sync_out_ch0));
   c_clear: cover property ($fell(lam));
endmodule
bind hpi_top hpi_chk #(.WIDTH(WIDTH)) hpi_chk_inst (.*);
`default_nettype wire

// File: sim/hpi_periph.sv
/* hpi_periph: slave peripheral for one channel.
 assumes a request pulse synchronous to clock. */
`timescale 1ns/10ps
`default_nettype none
module hpi_periph (
   input wire logic clock,
   input wire logic req,
   input wire logic slow,
   input wire logic [23:0] word,
   output logic [23:0] data,
   output logic strobe
);
   // one word per request, shown only around its strobe
   initial begin
      data = 24'h00_0000;
      strobe = 1'b0;
      forever begin
         @(posedge req);
         repeat (slow ? 8 : 1) @(negedge clock);
         data = word;
         @(negedge clock);
         strobe = 1'b1;
         repeat (2) @(negedge clock);
         strobe = 1'b0;
         @(negedge clock);
         data = ~word; // released, so never left looking valid
      end
   end
endmodule
`default_nettype wire

// File: sim/tb_top.sv
/* tb_top: self-checking bench for hpi_top.
 assumes one 100 MHz clock; ch1 talks to hpi_periph. */
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import hpi_pkg::*;
;
   logic clock, sys_rst, cmd_strobe, cmd_station, cmd_sub, q_resp, lam, slow;
   logic master_sync_in_ch0, master_sync_out_ch0, slave_sync_in_ch0, slave_sync_out_ch0;
   logic master_sync_in_ch1, master_sync_out_ch1, slave_sync_in_ch1, slave_sync_out_ch1;
   logic trigger_ch0, trigger_ch1;
   logic [4:0] cmd_func;
   logic [23:0] periph_data_ch0, periph_data_ch1, read_data, p_word;
   hpi_mode_type mode_ch0, mode_ch1;
   int n_mismatch = 0;
   int comparisons = 0;
   logic [24:0] rows [3] = '{25'h1ff_ffff, 25'h180_0001, 25'h15a_a5a5}; // q, word
   hpi_top hpi_top_inst (.*);
   hpi_periph hpi_periph_inst (.clock(clock), .req(master_sync_out_ch1), .slow(slow),
      .word(p_word), .data(periph_data_ch1), .strobe(slave_sync_in_ch1));
   // 10 ns period
   always #5 clock = ~clock;
   task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d bad %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // straps only move under reset
   task automatic rst(input hpi_mode_type m0, input hpi_mode_type m1);
      sys_rst = 1'b1;
      mode_ch0 = m0;
      mode_ch1 = m1;
      repeat (4) @(negedge clock);
      sys_rst = 1'b0;
   endtask
   task automatic cyc(input logic [4:0] f, input logic a);
      @(negedge clock);
      cmd_strobe = 1'b1;
      cmd_func = f;
      cmd_sub = a;
      repeat (2) @(negedge clock);
      cmd_strobe = 1'b0;
      repeat (2) @(negedge clock);
   endtask
   // ch0 word by handshake strobe or trigger
   task automatic push(input logic [23:0] w, input logic trig);
      @(negedge clock);
      periph_data_ch0 = w;
      {trigger_ch0, master_sync_in_ch0} = trig ? 2'h2 : 2'h1;
      repeat (2) @(negedge clock);
      {trigger_ch0, master_sync_in_ch0} = 2'h0;
      @(negedge clock);
      periph_data_ch0 = ~w;
   endtask
   // watchdog: the run needs under 1000 cycles
   initial begin
      #100000;
      n_mismatch++;
      report_and_stop();
   end
   // main sequence
   initial begin
      clock = 1'b0;
      {cmd_strobe, cmd_sub, slow, master_sync_in_ch0, trigger_ch0} = 5'h00;
      {slave_sync_in_ch0, master_sync_in_ch1, trigger_ch1, cmd_station} = 4'h1;
      cmd_func = 5'h00;
      periph_data_ch0 = 24'h00_0000;
      p_word = 24'h3c_00c3;
      rst(HPI_MODE_PERIPH_MASTER, HPI_MODE_PERIPH_SLAVE);
      foreach (rows[i]) begin
         push(rows[i][23:0], 1'b0);
         chk("lam up", 24'(lam), 24'h00_0001);
         cyc(HPI_F_READ, 1'b0);
         chk("data", read_data, rows[i][23:0]);
         chk("q", 24'(q_resp), 24'(rows[i][24]));
         chk("lam", 24'(lam), 24'h00_0000);
         chk("ack", 24'(slave_sync_out_ch0), 24'h00_0001);
         repeat (12) @(negedge clock);
         chk("ack end", 24'(slave_sync_out_ch0), 24'h00_0000);
      end
      // second strobe while lam is up is ignored
      push(24'h12_3456, 1'b0);
      push(24'h65_4321, 1'b0);
      cyc(HPI_F_READ, 1'b0);
      chk("held", read_data, 24'h12_3456);
      cyc(HPI_F_READ, 1'b0);
      chk("stale q", 24'(q_resp), 24'h00_0000);
      cyc(5'h01, 1'b0);
      // L mask, test and clear codes on a pending word
      push(24'h0a_0b0c, 1'b0);
      cyc(HPI_F_DISABLE_LAM, 1'b0);
      chk("lam off", 24'(lam), 24'h00_0000);
      cyc(HPI_F_TEST_LAM, 1'b0);
      chk("test q", 24'(q_resp), 24'h00_0001);
      cyc(HPI_F_ENABLE_LAM, 1'b0);
      chk("lam on", 24'(lam), 24'h00_0001);
      cyc(HPI_F_CLEAR_LAM, 1'b0);
      chk("lam clr", 24'(lam), 24'h00_0000);
      cyc(HPI_F_TEST_LAM, 1'b0);
      chk("test q0", 24'(q_resp), 24'h00_0000);
      for (int s = 0; s < 2; s++) begin
         slow = s[0];
         p_word = p_word + 24'h00_0001;
         cyc(HPI_F_REQUEST, 1'b1);
         chk("req q", 24'(q_resp), 24'h00_0001);
         repeat (16) @(negedge clock);
         cyc(HPI_F_READ, 1'b1);
         chk("slave", read_data, p_word);
      end
      // reset in mid-run while L is pending must clear every answer
      push(24'h33_cc33, 1'b0);
      chk("lam pend", 24'(lam), 24'h00_0001);
      rst(HPI_MODE_PERIPH_SLAVE, HPI_MODE_PERIPH_MASTER);
      chk("rst lam", 24'(lam), 24'h00_0000);
      chk("rst data", read_data, 24'h00_0000);
      chk("rst q", 24'(q_resp), 24'h00_0000);
      // swapped roles: ch0 slave driven by hand, ch1 master on the idle model word
      cyc(HPI_F_REQUEST, 1'b0);
      chk("req ch0", 24'(master_sync_out_ch0), 24'h00_0001);
      periph_data_ch0 = 24'h71_8293;
      @(negedge clock);
      slave_sync_in_ch0 = 1'b1;
      @(negedge clock);
      slave_sync_in_ch0 = 1'b0;
      master_sync_in_ch1 = 1'b1;
      @(negedge clock);
      master_sync_in_ch1 = 1'b0;
      chk("lam both", 24'(lam), 24'h00_0001);
      cyc(HPI_F_READ, 1'b0);
      chk("slave ch0", read_data, 24'h71_8293);
      chk("no ack ch0", 24'(slave_sync_out_ch0), 24'h00_0000);
      cyc(HPI_F_READ, 1'b1);
      chk("master ch1", read_data, ~p_word);
      chk("ack ch1", 24'(slave_sync_out_ch1), 24'h00_0001);
      chk("lam gone", 24'(lam), 24'h00_0000);
      rst(HPI_MODE_PATTERN, HPI_MODE_PERIPH_SLAVE);
      push(24'h0f_f0f0, 1'b1);
      cyc(HPI_F_READ, 1'b0);
      chk("pattern", read_data, 24'h0f_f0f0);
      rst(HPI_MODE_STATIC, HPI_MODE_STATIC);
      periph_data_ch0 = 24'h24_6801;
      cyc(HPI_F_READ, 1'b0);
      chk("static", read_data, 24'h24_6801);
      // strobes are ignored in static mode; the last level on the pins is read
      push(24'h13_5790, 1'b0);
      cyc(HPI_F_READ, 1'b0);
      chk("static fol", read_data, 24'hec_a86f);
      chk("static lam", 24'(lam), 24'h00_0000);
      chk("static q", 24'(q_resp), 24'h00_0001);
      report_and_stop();
   end
endmodule
`default_nettype wire
